// ===== core/sbl_pkg.sv
// Constants, types and state records of the serial boot loader.
// Assumes one 40 MHz clock and a byte memory with one-cycle read latency.
// What this block does
// - Wait for sync byte 5AH; receiving it fixes the link at 9600 bps.
// - Echo 5AH on success; otherwise stay silent and wait again.
// - Echo a valid baud code; switch rate only after the echo.
// - Invalid baud code: send 62H three times, then halt.
// - Every coded halt sends A1H x3 and A3H x3 first.
// - Third byte 30H selects flash writing; echo it at new rate.
// - Unsupported command: send 63H three times, then halt.
// - Command 60H selects RAM loading and is echoed.
// - Count address arrives high then low; nothing is returned.
// - Compare address arrives high then low; nothing is returned.
// - Reception or password error on address bytes halts silently.
// - Read N, compare N bytes against memory; mismatch halts silently.
// - All FFH from FFE0H to FFFFH means blank; skip password.
// - Records are not echoed; bytes before start mark 3AH dropped.
// - Record is length, address, type, data, checksum.
// - After a clean end record send image checksum, upper byte first.
// - Flash mode returns to waiting for a command after checksum.
// - RAM mode jumps to the first data record address.
// - RAM mode writes record data at the record address.
// - Reception or format error in records halts silently.
package sbl_pkg;
    localparam int CLK_HZ = 40_000_000;
    localparam int BAUD_INIT = 9600;
    localparam int BIT_CYC_9600 = (CLK_HZ + BAUD_INIT / 2) / BAUD_INIT;
    localparam logic [7:0] SYNC_BYTE = 8'h5a;
    localparam logic [7:0] CODE_9600 = 8'h28;
    localparam logic [7:0] CODE_19200 = 8'h18;
    localparam logic [7:0] CODE_38400 = 8'h10;
    localparam logic [7:0] CMD_FLASH = 8'h30;
    localparam logic [7:0] CMD_RAM = 8'h60;
    localparam logic [7:0] ERR_PRE1 = 8'ha1;
    localparam logic [7:0] ERR_PRE2 = 8'ha3;
    localparam logic [7:0] ERR_BAUD = 8'h62;
    localparam logic [7:0] ERR_CMD = 8'h63;
    localparam logic [7:0] ERR_REP = 8'h03;
    localparam logic [7:0] START_MARK = 8'h3a;
    localparam logic [15:0] BLANK_FIRST = 16'hffe0;
    localparam logic [7:0] BLANK_LEN = 8'h20;
    localparam logic [7:0] BLANK_BYTE = 8'hff;
    localparam logic [7:0] REC_DATA = 8'h00;
    localparam logic [7:0] REC_END = 8'h01;

    typedef enum logic [4:0] {
        ST_SYNC, ST_SYNC_ECHO, ST_BAUD, ST_BAUD_ECHO, ST_CMD, ST_CMD_ECHO,
        ST_ADDR, ST_BLANK, ST_COUNT, ST_PWD, ST_HUNT, ST_REC, ST_SUM,
        ST_JUMP, ST_ERR, ST_HALT
    } sbl_state_t;

    typedef struct packed {
        logic req;
        logic we;
        logic ram;
        logic [15:0] addr;
        logic [7:0] wdata;
    } sbl_mem_t;

    typedef struct packed {
        sbl_state_t st;
        logic ram_mode;
        logic [15:0] div;
        logic [1:0] shift;
        logic [7:0] idx;
        logic [15:0] cnt_addr;
        logic [15:0] cmp_addr;
        logic [7:0] pw_len;
        logic [7:0] pw_byte;
        logic rd_pend;
        logic [7:0] rec_len;
        logic [15:0] rec_addr;
        logic [7:0] rec_type;
        logic [7:0] rec_sum;
        logic [15:0] img_sum;
        logic first_seen;
        logic [15:0] jump_addr;
        logic jump_valid;
        logic [7:0] err_code;
        logic tx_start;
        logic [7:0] tx_data;
        sbl_mem_t mem;
        logic halted;
    } sbl_core_t;

    typedef struct packed {
        logic s1, s2, s3, lvl;
        logic rx_on;
        logic [15:0] rx_cnt;
        logic [3:0] rx_bit;
        logic [7:0] rx_sh;
        logic rx_valid, rx_err;
        logic [7:0] rx_data;
        logic [15:0] tx_cnt;
        logic [3:0] tx_bit;
        logic [8:0] tx_sh;
        logic tx_busy, txd;
    } sbl_uart_t;
endpackage : sbl_pkg

// ===== core/sbl_uart.sv
// Byte UART, 8 data bits, one stop bit, divisor set by the caller.
// Assumes rxd is asynchronous; divisor changes only while idle.
module sbl_uart (
    input wire logic clk_sys,
    input wire logic reset,
    input wire logic rxd,
    input wire logic [15:0] div,
    input wire logic tx_valid,
    input wire logic [7:0] tx_data,
    output logic rx_valid,
    output logic rx_err,
    output logic [7:0] rx_data,
    output logic tx_busy,
    output logic txd
);
    localparam sbl_pkg::sbl_uart_t RST = '{s1: 1'b1, s2: 1'b1, s3: 1'b1,
        lvl: 1'b1, txd: 1'b1, default: '0};
    sbl_pkg::sbl_uart_t u_r, u_nxt;

    always_comb begin
        u_nxt = u_r;
        u_nxt.s1 = rxd;
        u_nxt.s2 = u_r.s1;
        u_nxt.s3 = u_r.s2;
        // Line level moves only when the two later stages agree
        if (u_r.s2 == u_r.s3) begin
            u_nxt.lvl = u_r.s3;
        end
        u_nxt.rx_valid = 1'b0;
        if (!u_r.rx_on) begin
            if (!u_r.lvl) begin
                u_nxt.rx_on = 1'b1;
                u_nxt.rx_cnt = {1'b0, div[15:1]};
                u_nxt.rx_bit = 4'h0;
            end
        end else if (u_r.rx_cnt != 16'h0000) begin
            u_nxt.rx_cnt = u_r.rx_cnt - 16'h0001;
        end else begin
            u_nxt.rx_cnt = div - 16'h0001;
            if (u_r.rx_bit == 4'h0) begin
                u_nxt.rx_on = !u_r.lvl;
                u_nxt.rx_bit = 4'h1;
            end else if (u_r.rx_bit <= 4'h8) begin
                u_nxt.rx_sh = {u_r.lvl, u_r.rx_sh[7:1]};
                u_nxt.rx_bit = u_r.rx_bit + 4'h1;
            end else begin
                u_nxt.rx_valid = 1'b1;
                u_nxt.rx_data = u_r.rx_sh;
                u_nxt.rx_err = !u_r.lvl;
                u_nxt.rx_on = 1'b0;
            end
        end
        if (!u_r.tx_busy) begin
            if (tx_valid) begin
                u_nxt.tx_busy = 1'b1;
                u_nxt.txd = 1'b0;
                u_nxt.tx_sh = {1'b1, tx_data};
                u_nxt.tx_bit = 4'h0;
                u_nxt.tx_cnt = div - 16'h0001;
            end
        end else if (u_r.tx_cnt != 16'h0000) begin
            u_nxt.tx_cnt = u_r.tx_cnt - 16'h0001;
        end else if (u_r.tx_bit == 4'h9) begin
            u_nxt.tx_busy = 1'b0;
            u_nxt.txd = 1'b1;
        end else begin
            u_nxt.txd = u_r.tx_sh[0];
            u_nxt.tx_sh = {1'b1, u_r.tx_sh[8:1]};
            u_nxt.tx_bit = u_r.tx_bit + 4'h1;
            u_nxt.tx_cnt = div - 16'h0001;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            u_r <= RST;
        end else begin
            u_r <= u_nxt;
        end
    end

    assign rx_valid = u_r.rx_valid;
    assign rx_err = u_r.rx_err;
    assign rx_data = u_r.rx_data;
    assign tx_busy = u_r.tx_busy;
    assign txd = u_r.txd;
endmodule : sbl_uart

// ===== core/sbl_loader.sv
// Serial boot command handler: sync, baud change, command, password, records.
// Assumes mem_rdata is valid the cycle after a read request is registered.
module sbl_loader #(
    parameter logic [15:0] BIT_CYC_INIT = 16'(sbl_pkg::BIT_CYC_9600)
) (
    input wire logic clk_sys,
    input wire logic reset,
    input wire logic rxd,
    output logic txd,
    output sbl_pkg::sbl_mem_t mem_o,
    input wire logic [7:0] mem_rdata,
    output logic jump_valid,
    output logic [15:0] jump_addr,
    output logic halted
);
    localparam sbl_pkg::sbl_core_t RST = '{st: sbl_pkg::ST_SYNC,
        div: BIT_CYC_INIT, default: '0};
    sbl_pkg::sbl_core_t s, n;
    logic rx_valid;
    logic rx_err;
    logic [7:0] rx_data;
    logic tx_busy;
    logic tx_ready;
    logic rx_ok;
    logic [2:0] baud;

    // ****************************************
    // Baud code decode: valid flag and divisor shift
    // ****************************************
    function automatic logic [2:0] baud_decode(input logic [7:0] code);
        case (code)
            sbl_pkg::CODE_9600: baud_decode = 3'h4;
            sbl_pkg::CODE_19200: baud_decode = 3'h5;
            sbl_pkg::CODE_38400: baud_decode = 3'h6;
            default: baud_decode = 3'h0;
        endcase
    endfunction : baud_decode

    sbl_uart u_uart (
        .clk_sys(clk_sys),
        .reset(reset),
        .rxd(rxd),
        .div(s.div),
        .tx_valid(s.tx_start),
        .tx_data(s.tx_data),
        .rx_valid(rx_valid),
        .rx_err(rx_err),
        .rx_data(rx_data),
        .tx_busy(tx_busy),
        .txd(txd)
    );

    assign tx_ready = !s.tx_start && !tx_busy;
    assign rx_ok = rx_valid && !rx_err;
    assign baud = baud_decode(rx_data);

    // ****************************************
    // Command sequencer
    // ****************************************
    always_comb begin
        n = s;
        n.tx_start = 1'b0;
        n.mem.req = 1'b0;
        n.mem.we = 1'b0;
        n.rd_pend = s.mem.req && !s.mem.we;
        n.halted = (s.st == sbl_pkg::ST_HALT);
        case (s.st)
            sbl_pkg::ST_SYNC: begin
                if (rx_ok && rx_data == sbl_pkg::SYNC_BYTE) begin
                    n.st = sbl_pkg::ST_SYNC_ECHO;
                end
            end
            sbl_pkg::ST_SYNC_ECHO: begin
                if (tx_ready) begin
                    n.tx_start = 1'b1;
                    n.tx_data = sbl_pkg::SYNC_BYTE;
                    n.st = sbl_pkg::ST_BAUD;
                end
            end
            sbl_pkg::ST_BAUD: begin
                if (rx_valid && rx_err) begin
                    n.st = sbl_pkg::ST_HALT;
                end else if (rx_ok && baud[2]) begin
                    n.shift = baud[1:0];
                    n.tx_data = rx_data;
                    n.idx = 8'h00;
                    n.st = sbl_pkg::ST_BAUD_ECHO;
                end else if (rx_ok) begin
                    n.err_code = sbl_pkg::ERR_BAUD;
                    n.idx = 8'h00;
                    n.st = sbl_pkg::ST_ERR;
                end
            end
            sbl_pkg::ST_BAUD_ECHO: begin
                if (tx_ready && s.idx == 8'h00) begin
                    n.tx_start = 1'b1;
                    n.idx = 8'h01;
                end else if (tx_ready) begin
                    n.div = BIT_CYC_INIT >> s.shift;
                    n.st = sbl_pkg::ST_CMD;
                end
            end
            sbl_pkg::ST_CMD: begin
                if (rx_valid && rx_err) begin
                    n.st = sbl_pkg::ST_HALT;
                end else if (rx_ok && (rx_data == sbl_pkg::CMD_FLASH
                        || rx_data == sbl_pkg::CMD_RAM)) begin
                    n.ram_mode = (rx_data == sbl_pkg::CMD_RAM);
                    n.tx_data = rx_data;
                    n.img_sum = 16'h0000;
                    n.first_seen = 1'b0;
                    n.st = sbl_pkg::ST_CMD_ECHO;
                end else if (rx_ok) begin
                    n.err_code = sbl_pkg::ERR_CMD;
                    n.idx = 8'h00;
                    n.st = sbl_pkg::ST_ERR;
                end
            end
            sbl_pkg::ST_CMD_ECHO: begin
                if (tx_ready) begin
                    n.tx_start = 1'b1;
                    n.idx = 8'h00;
                    n.st = sbl_pkg::ST_ADDR;
                end
            end
            sbl_pkg::ST_ADDR: begin
                if (rx_valid && rx_err) begin
                    n.st = sbl_pkg::ST_HALT;
                end else if (rx_ok) begin
                    // Four silent bytes: count address, then compare address
                    case (s.idx[1:0])
                        2'h0: n.cnt_addr[15:8] = rx_data;
                        2'h1: n.cnt_addr[7:0] = rx_data;
                        2'h2: n.cmp_addr[15:8] = rx_data;
                        default: n.cmp_addr[7:0] = rx_data;
                    endcase
                    n.idx = s.idx + 8'h01;
                    if (s.idx == 8'h03) begin
                        n.idx = 8'h00;
                        n.st = sbl_pkg::ST_BLANK;
                    end
                end
            end
            sbl_pkg::ST_BLANK: begin
                if (s.rd_pend) begin
                    if (mem_rdata != sbl_pkg::BLANK_BYTE) begin
                        n.st = sbl_pkg::ST_COUNT;
                    end else if (s.idx == sbl_pkg::BLANK_LEN - 8'h01) begin
                        n.st = sbl_pkg::ST_HUNT;
                    end else begin
                        n.idx = s.idx + 8'h01;
                    end
                end else if (!s.mem.req) begin
                    n.mem.req = 1'b1;
                    n.mem.ram = 1'b0;
                    n.mem.addr = sbl_pkg::BLANK_FIRST + {8'h00, s.idx};
                end
            end
            sbl_pkg::ST_COUNT: begin
                if (s.rd_pend) begin
                    n.pw_len = mem_rdata;
                    n.idx = 8'h00;
                    // An empty count points at a wrong location
                    n.st = (mem_rdata == 8'h00) ? sbl_pkg::ST_HALT
                                                : sbl_pkg::ST_PWD;
                end else if (!s.mem.req) begin
                    n.mem.req = 1'b1;
                    n.mem.ram = 1'b0;
                    n.mem.addr = s.cnt_addr;
                end
            end
            sbl_pkg::ST_PWD: begin
                if (s.rd_pend) begin
                    if (mem_rdata != s.pw_byte) begin
                        n.st = sbl_pkg::ST_HALT;
                    end else if (s.idx == s.pw_len - 8'h01) begin
                        n.st = sbl_pkg::ST_HUNT;
                    end else begin
                        n.idx = s.idx + 8'h01;
                    end
                end else if (rx_valid && rx_err) begin
                    n.st = sbl_pkg::ST_HALT;
                end else if (rx_ok) begin
                    n.pw_byte = rx_data;
                    n.mem.req = 1'b1;
                    n.mem.ram = 1'b0;
                    n.mem.addr = s.cmp_addr + {8'h00, s.idx};
                end
            end
            sbl_pkg::ST_HUNT: begin
                if (rx_valid && rx_err) begin
                    n.st = sbl_pkg::ST_HALT;
                end else if (rx_ok && rx_data == sbl_pkg::START_MARK) begin
                    n.idx = 8'h00;
                    n.rec_sum = 8'h00;
                    n.st = sbl_pkg::ST_REC;
                end
            end
            sbl_pkg::ST_REC: begin
                if (rx_valid && rx_err) begin
                    n.st = sbl_pkg::ST_HALT;
                end else if (rx_ok) begin
                    n.rec_sum = s.rec_sum + rx_data;
                    n.idx = s.idx + 8'h01;
                    case (s.idx)
                        8'h00: n.rec_len = rx_data;
                        8'h01: n.rec_addr[15:8] = rx_data;
                        8'h02: n.rec_addr[7:0] = rx_data;
                        8'h03: begin
                            n.rec_type = rx_data;
                            if (rx_data != sbl_pkg::REC_DATA
                                    && rx_data != sbl_pkg::REC_END) begin
                                n.st = sbl_pkg::ST_HALT;
                            end else if (rx_data == sbl_pkg::REC_DATA
                                    && !s.first_seen) begin
                                n.first_seen = 1'b1;
                                n.jump_addr = s.rec_addr;
                            end
                        end
                        default: begin
                            n.idx = s.idx;
                            if (s.rec_len != 8'h00) begin
                                n.rec_len = s.rec_len - 8'h01;
                                n.rec_addr = s.rec_addr + 16'h0001;
                                if (s.rec_type == sbl_pkg::REC_DATA) begin
                                    n.mem.req = 1'b1;
                                    n.mem.we = 1'b1;
                                    n.mem.ram = s.ram_mode;
                                    n.mem.addr = s.rec_addr;
                                    n.mem.wdata = rx_data;
                                    n.img_sum = s.img_sum + {8'h00, rx_data};
                                end
                            end else if (s.rec_sum + rx_data != 8'h00) begin
                                n.st = sbl_pkg::ST_HALT;
                            end else if (s.rec_type == sbl_pkg::REC_END) begin
                                n.idx = 8'h00;
                                n.st = sbl_pkg::ST_SUM;
                            end else begin
                                n.st = sbl_pkg::ST_HUNT;
                            end
                        end
                    endcase
                end
            end
            sbl_pkg::ST_SUM: begin
                if (tx_ready) begin
                    n.idx = s.idx + 8'h01;
                    if (s.idx == 8'h00) begin
                        n.tx_start = 1'b1;
                        n.tx_data = s.img_sum[15:8];
                    end else if (s.idx == 8'h01) begin
                        n.tx_start = 1'b1;
                        n.tx_data = s.img_sum[7:0];
                    end else if (s.ram_mode) begin
                        n.st = sbl_pkg::ST_JUMP;
                    end else begin
                        n.st = sbl_pkg::ST_CMD;
                    end
                end
            end
            sbl_pkg::ST_JUMP: begin
                n.jump_valid = 1'b1;
            end
            sbl_pkg::ST_ERR: begin
                if (tx_ready) begin
                    n.idx = s.idx + 8'h01;
                    if (s.idx == 3 * sbl_pkg::ERR_REP) begin
                        n.st = sbl_pkg::ST_HALT;
                    end else begin
                        n.tx_start = 1'b1;
                        if (s.idx < sbl_pkg::ERR_REP) begin
                            n.tx_data = sbl_pkg::ERR_PRE1;
                        end else if (s.idx < 2 * sbl_pkg::ERR_REP) begin
                            n.tx_data = sbl_pkg::ERR_PRE2;
                        end else begin
                            n.tx_data = s.err_code;
                        end
                    end
                end
            end
            sbl_pkg::ST_HALT: begin
                n.st = sbl_pkg::ST_HALT;
            end
            default: begin
                n.st = sbl_pkg::ST_HALT;
            end
        endcase
    end

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            s <= RST;
        end else begin
            s <= n;
        end
    end

    assign mem_o = s.mem;
    assign jump_valid = s.jump_valid;
    assign jump_addr = s.jump_addr;
    assign halted = s.halted;

    // ****************************************
    // Checks
    // ****************************************
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (reset);

    AST_SYNC_ECHO:
    assert property (s.st == sbl_pkg::ST_SYNC && rx_ok && rx_data == sbl_pkg::SYNC_BYTE
        |-> ##2 (s.tx_start && s.tx_data == sbl_pkg::SYNC_BYTE))
        else $error("sync byte not echoed");
    AST_SYNC_RETRY:
    assert property (s.st == sbl_pkg::ST_SYNC && rx_valid
        && (rx_err || rx_data != sbl_pkg::SYNC_BYTE)
        |=> (s.st == sbl_pkg::ST_SYNC && !s.tx_start) [*2])
        else $error("bad sync byte answered");
    AST_BAUD_LATE:
    assert property ($changed(s.div) |-> $past(s.st) == sbl_pkg::ST_BAUD_ECHO
        && $past(s.idx) == 8'h01 && !$past(tx_busy))
        else $error("rate changed before echo done");
    AST_ERR_ORDER:
    assert property (s.st == sbl_pkg::ST_ERR && s.tx_start |-> s.tx_data ==
        (s.idx <= 8'h03 ? sbl_pkg::ERR_PRE1 : s.idx <= 8'h06 ? sbl_pkg::ERR_PRE2
        : s.err_code))
        else $error("error burst out of order");
    AST_CMD_BAD:
    assert property (s.st == sbl_pkg::ST_CMD && rx_ok && rx_data != sbl_pkg::CMD_FLASH
        && rx_data != sbl_pkg::CMD_RAM
        |=> s.st == sbl_pkg::ST_ERR && s.err_code == sbl_pkg::ERR_CMD && s.idx == 8'h00)
        else $error("bad command not reported");
    AST_QUIET:
    assert property (s.st inside {sbl_pkg::ST_ADDR, sbl_pkg::ST_BLANK,
        sbl_pkg::ST_COUNT, sbl_pkg::ST_PWD, sbl_pkg::ST_HUNT, sbl_pkg::ST_REC}
        |=> !s.tx_start)
        else $error("transmit during silent phase");
    AST_PWD_MISMATCH:
    assert property (s.st == sbl_pkg::ST_PWD && s.rd_pend && mem_rdata != s.pw_byte
        |=> s.st == sbl_pkg::ST_HALT ##1 halted)
        else $error("password mismatch not halted");
    AST_SUM_HI:
    assert property (s.st == sbl_pkg::ST_SUM && s.tx_start && s.idx == 8'h01
        |-> s.tx_data == s.img_sum[15:8])
        else $error("checksum upper byte wrong");
    AST_RAM_WRITE:
    assert property (s.st == sbl_pkg::ST_REC && rx_ok && s.idx == 8'h04
        && s.rec_len != 8'h00 && s.rec_type == sbl_pkg::REC_DATA
        |=> s.mem.we && s.mem.addr == $past(s.rec_addr) && s.mem.wdata == $past(rx_data))
        else $error("record data not written");
    AST_HALT_STAYS:
    assert property (s.st == sbl_pkg::ST_HALT |=> s.st == sbl_pkg::ST_HALT && !s.tx_start)
        else $error("halt left before reset");

    COV_SYNCED: cover property (s.st == sbl_pkg::ST_SYNC_ECHO ##1 s.st == sbl_pkg::ST_BAUD);
    COV_FLASH_DONE: cover property (s.st == sbl_pkg::ST_SUM ##1 s.st == sbl_pkg::ST_CMD);
    COV_JUMP: cover property (s.st == sbl_pkg::ST_JUMP && s.jump_valid);
    COV_ERR_HALT: cover property (s.st == sbl_pkg::ST_ERR ##1 s.st == sbl_pkg::ST_HALT);
endmodule : sbl_loader

// ===== test/sbl_host.sv
// Model of the external programming controller on the UART link.
// Assumes 8N1 frames; the bench sets bit_cyc to the current bit time.
module sbl_host #(
    parameter int BIT = 16
) (
    input wire logic clk_sys,
    input wire logic txd,
    output logic rxd
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] got_q[$];
    logic [7:0] sh;
    int bit_cyc = BIT;
    initial rxd = 1'b1;
    // Start bit, data LSB first, stop bit; line rests high
    task automatic send_byte(input logic [7:0] b);
        logic [9:0] fr;
        fr = {1'b1, b, 1'b0};
        for (int i = 0; i < 10; i++) begin
            @(negedge clk_sys);
            rxd = fr[i];
            repeat (bit_cyc - 1) @(negedge clk_sys);
        end
    endtask : send_byte
    // Collect every byte the loader sends
    always begin
        @(negedge txd);
        repeat (bit_cyc / 2) @(negedge clk_sys);
        for (int i = 0; i < 8; i++) begin
            repeat (bit_cyc) @(negedge clk_sys);
            sh = {txd, sh[7:1]};
        end
        got_q.push_back(sh);
    end
endmodule : sbl_host

// ===== test/tb.sv
// Bench of the serial boot loader: flash and RAM loads, password, errors, halt.
// Memory reads FFH while blank, else count 02H at 1234H and the low address byte.
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_sys, reset, rxd, txd, jump_valid, halted, wr_ram;
    logic blank = 1'b1;
    logic [15:0] jump_addr, wr_addr;
    logic [7:0] wr_data;
    logic [7:0] rdata = 8'hff;
    sbl_pkg::sbl_mem_t mem_o;
    int fails = 0, checks_done = 0, cyc = 0;
    sbl_loader #(.BIT_CYC_INIT(16'h0010)) u_dut (.clk_sys(clk_sys), .reset(reset),
        .rxd(rxd), .txd(txd), .mem_o(mem_o), .mem_rdata(rdata),
        .jump_valid(jump_valid), .jump_addr(jump_addr), .halted(halted));
    sbl_host #(.BIT(16)) u_host (.clk_sys(clk_sys), .txd(txd), .rxd(rxd));
    initial begin
        clk_sys = 1'b0;
        forever #12.5 clk_sys = ~clk_sys;
    end
    always @(negedge clk_sys) begin
        cyc++;
        if (mem_o.req && mem_o.we) begin
            wr_addr = mem_o.addr;
            wr_data = mem_o.wdata;
            wr_ram = mem_o.ram;
        end
        if (mem_o.req && !mem_o.we) begin
            rdata = blank ? 8'hff : (mem_o.addr == 16'h1234) ? 8'h02 : mem_o.addr[7:0];
        end
        if (cyc == 30000) begin
            fails++;
            end_sim();
        end
    end
    task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
        checks_done++;
        if (got !== exp) begin
            fails++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : cmp
    task automatic rx_chk(input logic [7:0] exp);
        int n;
        n = 0;
        while (u_host.got_q.size() == 0 && n < 400) begin
            @(negedge clk_sys);
            n++;
        end
        cmp((n < 400) ? {8'h00, u_host.got_q.pop_front()} : 16'h0100, {8'h00, exp});
    endtask : rx_chk
    task automatic echo(input logic [7:0] b);
        u_host.send_byte(b);
        rx_chk(b);
        // Let the echo's stop bit end before the next byte
        repeat (2 * u_host.bit_cyc) @(negedge clk_sys);
    endtask : echo
    task automatic t_boot();
        echo(8'h5a);
        echo(8'h28);
        echo(8'h30);
    endtask : t_boot
    task automatic t_records();
        logic [7:0] s[18] = '{8'h12, 8'h34, 8'h56, 8'h78, 8'h00, 8'h3a, 8'h01, 8'h00,
            8'h10, 8'h00, 8'h55, 8'h9a, 8'h3a, 8'h00, 8'h00, 8'h00, 8'h01, 8'hff};
        foreach (s[i]) u_host.send_byte(s[i]);
        rx_chk(8'h00);
        rx_chk(8'h55);
        cmp(wr_addr, 16'h0010);
        cmp({wr_ram, 7'h00, wr_data}, 16'h0055);
    endtask : t_records
    task automatic t_err(input logic [7:0] bad, input logic [7:0] code);
        u_host.send_byte(bad);
        for (int i = 0; i < 9; i++) rx_chk((i < 3) ? 8'ha1 : (i < 6) ? 8'ha3 : code);
        repeat (40) @(negedge clk_sys);
        cmp({15'h0000, halted}, 16'h0001);
        u_host.send_byte(8'h5a);
        repeat (300) @(negedge clk_sys);
        cmp(16'(u_host.got_q.size()), 16'h0000);
    endtask : t_err
    task automatic t_reset();
        reset = 1'b1;
        repeat (4) @(negedge clk_sys);
        reset = 1'b0;
        u_host.bit_cyc = 16;
        cmp({14'h0000, halted, jump_valid}, 16'h0000);
    endtask : t_reset
    task automatic t_ram();
        logic [7:0] s[26] = '{8'h12, 8'h34, 8'h56, 8'h78, 8'h78, 8'h79, 8'h3a, 8'h01, 8'h01,
            8'h00, 8'h00, 8'ha5, 8'h59, 8'h3a, 8'h01, 8'h02, 8'h00, 8'h00, 8'h3c, 8'hc1,
            8'h3a, 8'h00, 8'h00, 8'h00, 8'h01, 8'hff};
        blank = 1'b0;
        echo(8'h5a);
        echo(8'h18);
        u_host.bit_cyc = 8;
        echo(8'h60);
        foreach (s[i]) u_host.send_byte(s[i]);
        rx_chk(8'h00);
        rx_chk(8'he1);
        cmp(wr_addr, 16'h0200);
        cmp({wr_ram, 7'h00, wr_data}, 16'h803c);
        repeat (40) @(negedge clk_sys);
        cmp({15'h0000, jump_valid}, 16'h0001);
        cmp(jump_addr, 16'h0100);
    endtask : t_ram
    task automatic t_pwd_bad();
        logic [7:0] p[5] = '{8'h12, 8'h34, 8'h56, 8'h78, 8'h77};
        t_boot();
        foreach (p[i]) u_host.send_byte(p[i]);
        repeat (40) @(negedge clk_sys);
        cmp({15'h0000, halted}, 16'h0001);
        cmp(16'(u_host.got_q.size()), 16'h0000);
    endtask : t_pwd_bad
    task automatic t_bad_baud();
        u_host.send_byte(8'h33);
        echo(8'h5a);
        t_err(8'h44, 8'h62);
    endtask : t_bad_baud
    task automatic end_sim();
        $display("Comparisons %0d, mismatches %0d", checks_done, fails);
        if (fails == 0 && checks_done > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : end_sim
    initial begin
        reset = 1'b1;
        repeat (12) @(negedge clk_sys);
        reset = 1'b0;
        t_boot();
        t_records();
        t_err(8'h77, 8'h63);
        t_reset();
        t_ram();
        t_reset();
        t_pwd_bad();
        t_reset();
        t_bad_baud();
        end_sim();
    end
endmodule : tb
